/* File: design/lvca_arbiter.sv */
// Virtual channel ordering and priority arbiter with a Wishbone control slave.
//
// What this block does
// [R1] Posted requests overtake stalled nonposted requests; ordinary posted waits only for its credit or for time-critical traffic.
// [R2] Responses overtake stalled nonposted requests.
// [R3] Posted requests overtake responses waiting at the head.
// [R4] A response never passes an older posted write in its lane, barring exceptions.
// [R5] High-priority mode has own posted, nonposted and response channels and buffers.
// [R6] Flagged reads and writes travel in the time-critical request channels.
// [R7] Flagged read replies and target-complete packets use the time-critical response channel.
// [R8] A no-operation credit packet with the flag set returns time-critical credits.
// [R9] Broadcast and atomic packets never enter or affect time-critical channels.
// [R10] Fence and flush use time-critical channels only when their flag is one.
// [R11] Cold reset leaves high-priority mode off; software sets it then warm resets.
// [R12] No ordering across lanes; fairness covers only ordinary traffic.
// [R13] Time-critical lane uses the same passing rules as the ordinary lane.
// [R14] Time-critical traffic always wins, strictly, with no starvation guard.
// [R15] High-priority mode is enabled per link.
// [R16] Isochronous sources mark their requests with the priority flag.
// [R17] A host may set the pass-posted flag on every downstream response.
// [R18] Reduced-latency option lets pass-posted responses overtake stalled posted requests.
// [R19] In normal mode no time-critical channels exist; credit packets carry flag zero.
// [R20] In normal mode the flag may be ignored; it is forwarded unchanged except that replies to flagged requests get it set.
// [R21] A reply to a flagged nonposted request carries the flag set.
// [R22] Posted requests are accepted with no dependency on other traffic.
// [R23] The mode enable is taken only as a warm reset ends.
// [R24] Reset-time credits come in per channel; a packet issues only with credit.
`timescale 1ns/1ps
`include "lvca_defines.svh"

module lvca_arbiter
#(
	parameter int CW = 4
)
(
	input  wire logic                              clk,
	input  wire logic                              nrst,
	input  wire logic                              warm_rst_n,
	input  wire logic                              in_valid,
	input  wire lvca_pkg::lvca_pkt_s               in_pkt,
	output logic      [`LVCA_NUM_VC-1:0]           in_ready,
	input  wire logic [`LVCA_NUM_VC-1:0][CW-1:0]   cred_init,
	input  wire logic [`LVCA_NUM_VC-1:0]           cred_ret,
	output logic                                   out_valid,
	output logic      [2:0]                        out_vc,
	output lvca_pkg::lvca_pkt_s                    out_pkt,
	output logic                                   rel_valid,
	output logic      [2:0]                        rel_vc,
	output logic                                   rel_isoc,
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [7:0]                        wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [31:0]                       wb_dat_i,
	output logic      [31:0]                       wb_dat_o,
	output logic                                   wb_ack_o
);

	// Control reset image held as a constant so single fields can be picked out of it.
	localparam logic [31:0] CTRL_RST = `LVCA_CTRL_RESET;

	// Channel class of a packet kind.
	function automatic logic [1:0] class_of(input lvca_pkg::lvca_kind_e k);
		unique case (k)
			lvca_pkg::KIND_WRITE_POSTED,
			lvca_pkg::KIND_BROADCAST,
			lvca_pkg::KIND_FENCE:       class_of = `LVCA_CLS_POSTED;
			lvca_pkg::KIND_READ_REPLY,
			lvca_pkg::KIND_TARGET_DONE: class_of = `LVCA_CLS_REPLY;
			default:                    class_of = `LVCA_CLS_NONPOSTED;
		endcase
	endfunction

	// True for kinds that may never ride the time-critical lane.
	function automatic logic lane_barred(input lvca_pkg::lvca_kind_e k);
		lane_barred = (k == lvca_pkg::KIND_BROADCAST) || (k == lvca_pkg::KIND_ATOMIC);
	endfunction

	logic                              ws_meta;
	logic                              ws_sync;
	logic                              ws_prev;
	logic                              warm_end;
	logic                              isoc_req;
	logic                              fast_reply;
	logic                              isoc_mode;
	logic [`LVCA_NUM_VC-1:0]           occ;
	lvca_pkg::lvca_pkt_s               slot [`LVCA_NUM_VC];
	logic [1:0]                        ahead;
	logic [`LVCA_NUM_VC-1:0][CW-1:0]   cred;
	logic [1:0]                        in_cls;
	logic                              in_lane;
	logic [2:0]                        in_idx;
	logic                              in_reply_isoc;
	logic [`LVCA_NUM_VC-1:0]           acc;
	logic [`LVCA_NUM_VC-1:0]           elig;
	logic [1:0]                        blk;
	logic [`LVCA_NUM_VC-1:0]           gnt;
	logic                              rr_reply;
	logic [2:0]                        gnt_idx;
	logic                              wb_hit;

	// The warm reset pin is asynchronous to clk; only ws_sync and its delayed copy ws_prev are read by logic.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ws_meta <= 1'b0;
			ws_sync <= 1'b0;
			ws_prev <= 1'b0;
		end
		else
		begin
			ws_meta <= ~warm_rst_n;
			ws_sync <= ws_meta;
			ws_prev <= ws_sync;
		end
	end

	assign warm_end = ws_prev & ~ws_sync;

	// Mode is frozen between warm resets so channel layout never shifts under live traffic.
	always_ff @(posedge clk)
	begin
		if (!nrst)
			isoc_mode <= 1'b0; // [R11]
		else if (warm_end)
			isoc_mode <= isoc_req; // [R23] [R15]
	end

	// Software control: the mode request and the reduced-latency reply option.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			isoc_req   <= CTRL_RST[`LVCA_CTRL_ISOC_BIT];
			fast_reply <= CTRL_RST[`LVCA_CTRL_FASTR_BIT];
		end
		else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `LVCA_CTRL_OFS)
		begin
			isoc_req   <= wb_dat_i[`LVCA_CTRL_ISOC_BIT]; // [R11]
			fast_reply <= wb_dat_i[`LVCA_CTRL_FASTR_BIT]; // [R18]
		end
	end

	// Classify the offered packet into its channel.
	always_comb
	begin
		in_cls        = class_of(in_pkt.kind);
		in_reply_isoc = (in_cls == `LVCA_CLS_REPLY) && in_pkt.reply_to_isoc; // [R21]
		// In high-priority mode a reply that gains the flag also rides the time-critical response channel.
		in_lane       = isoc_mode && (in_pkt.isoc || in_reply_isoc)
			&& !lane_barred(in_pkt.kind); // [R6] [R7] [R9] [R10]
		in_idx        = in_lane ? 3'(in_cls) + `LVCA_VC_P_I : 3'(in_cls); // [R5]
	end

	// Each channel slot is its own flow-control buffer; a free posted slot accepts alone.
	always_comb
	begin
		for (int i = 0; i < `LVCA_NUM_VC; i++)
			acc[i] = in_valid && in_ready[i] && (in_idx == 3'(i)); // [R22]
	end

	generate
		for (genvar g = 0; g < `LVCA_NUM_VC; g++)
		begin : g_slot
			// Slot storage; the ready flag mirrors emptiness so it leaves from a flop.
			always_ff @(posedge clk)
			begin
				if (!nrst || ws_sync)
				begin
					occ[g]      <= 1'b0;
					in_ready[g] <= 1'b1;
				end
				else if (acc[g])
				begin
					occ[g]      <= 1'b1;
					in_ready[g] <= 1'b0;
				end
				else if (gnt[g])
				begin
					occ[g]      <= 1'b0;
					in_ready[g] <= 1'b1;
				end
			end

			// Payload and flags are kept as received apart from the isoc flag of a reply.
			always_ff @(posedge clk)
			begin
				if (!nrst)
					slot[g] <= '0;
				else if (acc[g])
				begin
					slot[g]      <= in_pkt; // [R20]
					slot[g].isoc <= in_pkt.isoc | in_reply_isoc; // [R21]
				end
			end

			// Per-channel credit; loaded during reset, returned by pulses, spent on issue.
			always_ff @(posedge clk)
			begin
				if (!nrst || ws_sync)
					cred[g] <= cred_init[g]; // [R24]
				else if (cred_ret[g] && !gnt[g])
					cred[g] <= cred[g] + CW'(1);
				else if (!cred_ret[g] && gnt[g])
					cred[g] <= cred[g] - CW'(1);
			end
		end
	endgenerate

	generate
		for (genvar l = 0; l < 2; l++)
		begin : g_lane
			// Remember a posted write older than the response in the same lane.
			always_ff @(posedge clk)
			begin
				if (!nrst || ws_sync)
					ahead[l] <= 1'b0;
				else if (acc[3*l+2])
					ahead[l] <= occ[3*l] && !gnt[3*l]; // [R4]
				else if (gnt[3*l])
					ahead[l] <= 1'b0;
			end

			// A response waits on older posted data unless the fast option lets it pass.
			assign blk[l] = ahead[l] && !(fast_reply && slot[3*l+2].pass_posted_write_flag); // [R4] [R18]
		end
	endgenerate

	// A channel is eligible when it holds a packet, has credit and is not held back.
	always_comb
	begin
		for (int i = 0; i < `LVCA_NUM_VC; i++)
			elig[i] = occ[i] && (cred[i] != '0); // [R24]
		elig[`LVCA_VC_R_N] = elig[`LVCA_VC_R_N] && !blk[0];
		elig[`LVCA_VC_R_I] = elig[`LVCA_VC_R_I] && !blk[1]; // [R13]
	end

	// Lane choice is strict; inside a lane posted goes first, nonposted never blocks others.
	always_comb
	begin
		gnt = '0;
		if (elig[`LVCA_VC_P_I])
			gnt[`LVCA_VC_P_I] = 1'b1; // [R14] [R1] [R3] [R13]
		else if (elig[`LVCA_VC_R_I])
			gnt[`LVCA_VC_R_I] = 1'b1; // [R2] [R13]
		else if (elig[`LVCA_VC_NP_I])
			gnt[`LVCA_VC_NP_I] = 1'b1;
		else if (elig[`LVCA_VC_P_N])
			gnt[`LVCA_VC_P_N] = 1'b1; // [R1] [R3]
		else if (elig[`LVCA_VC_R_N] && (rr_reply || !elig[`LVCA_VC_NP_N]))
			gnt[`LVCA_VC_R_N] = 1'b1; // [R2] [R12]
		else if (elig[`LVCA_VC_NP_N])
			gnt[`LVCA_VC_NP_N] = 1'b1;
	end

	// Index of the granted channel.
	always_comb
	begin
		gnt_idx = 3'h0;
		for (int i = 0; i < `LVCA_NUM_VC; i++)
			if (gnt[i])
				gnt_idx = 3'(i);
	end

	// Fairness turn between ordinary responses and nonposted; isoc grants do not move it.
	always_ff @(posedge clk)
	begin
		if (!nrst)
			rr_reply <= 1'b1;
		else if (gnt[`LVCA_VC_R_N])
			rr_reply <= 1'b0; // [R12]
		else if (gnt[`LVCA_VC_NP_N])
			rr_reply <= 1'b1;
	end

	// Issue port: one packet a cycle, forwarded with its flags untouched.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			out_valid <= 1'b0;
			out_vc    <= 3'h0;
			out_pkt   <= '0;
		end
		else
		begin
			out_valid <= |gnt;
			out_vc    <= gnt_idx;
			out_pkt   <= slot[gnt_idx]; // [R20]
		end
	end

	// Buffer release toward the sender; the flag says which lane the credit is for.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rel_valid <= 1'b0;
			rel_vc    <= 3'h0;
			rel_isoc  <= 1'b0;
		end
		else
		begin
			rel_valid <= |gnt;
			rel_vc    <= gnt_idx;
			rel_isoc  <= isoc_mode && (gnt_idx >= `LVCA_VC_P_I); // [R8] [R19]
		end
	end

	// Classic Wishbone slave: ack one cycle after the strobe, dropped the cycle after.
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= 32'h0000_0000;
			if (wb_hit && !wb_we_i && wb_adr_i == `LVCA_CTRL_OFS)
			begin
				wb_dat_o[`LVCA_CTRL_ISOC_BIT]  <= isoc_req;
				wb_dat_o[`LVCA_CTRL_FASTR_BIT] <= fast_reply;
			end
			else if (wb_hit && !wb_we_i && wb_adr_i == `LVCA_STATUS_OFS)
			begin
				wb_dat_o[`LVCA_STAT_ISOC_BIT]                     <= isoc_mode;
				wb_dat_o[`LVCA_STAT_FASTR_BIT]                    <= fast_reply;
				wb_dat_o[`LVCA_STAT_OCC_MSB:`LVCA_STAT_OCC_LSB] <= occ;
			end
		end
	end

	// Pending time-critical work always takes the next issue slot.
	AST_ISOC_FIRST: assert property (@(posedge clk) disable iff (!nrst) // [R14]
		(|elig[`LVCA_VC_R_I:`LVCA_VC_P_I]) |=> (out_valid && out_vc >= `LVCA_VC_P_I))
		else $error("ordinary packet issued while time-critical work was ready");

	// An eligible ordinary posted write is not held back by nonposted or responses.
	AST_POSTED_PASS: assert property (@(posedge clk) disable iff (!nrst) // [R1]
		(elig[`LVCA_VC_P_N] && !(|elig[`LVCA_VC_R_I:`LVCA_VC_P_I]))
		|=> (out_valid && out_vc == `LVCA_VC_P_N))
		else $error("ordinary posted write did not issue");

	// An ordinary response behind an older posted write waits for it unless the fast option lets it pass.
	AST_REPLY_ORDER: assert property (@(posedge clk) disable iff (!nrst) // [R4]
		(gnt[`LVCA_VC_R_N] && occ[`LVCA_VC_P_N] && ahead[0]) |-> (fast_reply
		&& slot[`LVCA_VC_R_N].pass_posted_write_flag))
		else $error("response passed an older posted write");

	// Cold reset turns the mode off and it stays off until a warm reset ends.
	AST_COLD_OFF: assert property (@(posedge clk) // [R11]
		!nrst |=> !isoc_mode)
		else $error("high-priority mode active after cold reset");

	// The mode only changes at the end of a warm reset.
	AST_MODE_STABLE: assert property (@(posedge clk) disable iff (!nrst) // [R23]
		!warm_end |=> $stable(isoc_mode))
		else $error("mode changed outside a warm reset end");

	// No packet issues from a channel without credit.
	AST_CREDIT_GATE: assert property (@(posedge clk) disable iff (!nrst) // [R24]
		(|gnt) |-> (cred[gnt_idx] != '0))
		else $error("packet issued without credit");

	// Credit releases in normal mode never claim the time-critical lane.
	AST_NOP_FLAG: assert property (@(posedge clk) disable iff (!nrst) // [R19]
		(rel_valid && !isoc_mode) |-> !rel_isoc)
		else $error("time-critical credit flag sent in normal mode");

	// Broadcast and atomic packets never leave from a time-critical channel.
	AST_NO_ISOC_BCAST: assert property (@(posedge clk) disable iff (!nrst) // [R9]
		(out_valid && out_vc >= `LVCA_VC_P_I) |-> !lane_barred(out_pkt.kind))
		else $error("broadcast or atomic packet in time-critical lane");

	// A reply to a flagged request leaves with the flag set.
	AST_REPLY_ISOC: assert property (@(posedge clk) disable iff (!nrst) // [R21]
		(out_valid && class_of(out_pkt.kind) == `LVCA_CLS_REPLY && out_pkt.reply_to_isoc)
		|-> out_pkt.isoc)
		else $error("reply to flagged request lost its flag");

	// A free posted slot accepts an offered posted packet in the same cycle.
	AST_POSTED_ACCEPT: assert property (@(posedge clk) disable iff (!nrst || ws_sync) // [R22]
		acc[`LVCA_VC_P_N] |=> (occ[`LVCA_VC_P_N] && !in_ready[`LVCA_VC_P_N]))
		else $error("posted packet not taken into its slot");

endmodule

/* File: design/lvca_defines.svh */
// Register offsets, field positions, reset values and widths for the channel arbiter.
`ifndef LVCA_DEFINES_SVH
`define LVCA_DEFINES_SVH

// Byte addresses of the Wishbone registers.
`define LVCA_CTRL_OFS        8'h00
`define LVCA_STATUS_OFS      8'h04

// Control register fields.
`define LVCA_CTRL_ISOC_BIT   0
`define LVCA_CTRL_FASTR_BIT  1
`define LVCA_CTRL_RESET      32'h0000_0000

// Status register fields.
`define LVCA_STAT_ISOC_BIT   0
`define LVCA_STAT_FASTR_BIT  1
`define LVCA_STAT_OCC_LSB    8
`define LVCA_STAT_OCC_MSB    13

// Channel numbering: lane times three plus class.
`define LVCA_NUM_VC          6
`define LVCA_CLS_POSTED      2'h0
`define LVCA_CLS_NONPOSTED   2'h1
`define LVCA_CLS_REPLY       2'h2
`define LVCA_VC_P_N          3'h0
`define LVCA_VC_NP_N         3'h1
`define LVCA_VC_R_N          3'h2
`define LVCA_VC_P_I          3'h3
`define LVCA_VC_NP_I         3'h4
`define LVCA_VC_R_I          3'h5

`endif

/* File: design/lvca_pkg.sv */
// Types shared by the channel arbiter and its bench.
package lvca_pkg;

	// Packet kinds seen by the arbiter.
	typedef enum logic [3:0]
	{
		KIND_WRITE_POSTED,
		KIND_WRITE_NONPOSTED,
		KIND_READ,
		KIND_READ_REPLY,
		KIND_TARGET_DONE,
		KIND_BROADCAST,
		KIND_ATOMIC,
		KIND_FENCE,
		KIND_FLUSH
	} lvca_kind_e;

	// One packet as it moves through a channel slot.
	typedef struct packed
	{
		lvca_kind_e  kind;
		logic        isoc;
		logic        pass_posted_write_flag;
		logic        reply_to_isoc;
		logic [31:0] payload;
	} lvca_pkt_s;

endpackage

/* File: sim/lvca_arbiter_tb.sv */
// Self-checking bench for the channel arbiter with its far link partner.
`timescale 1ns/1ps
`include "lvca_defines.svh"

module lvca_arbiter_tb;
	logic                clk = 0;
	logic                nrst = 0;
	logic                warm_rst_n = 1;
	logic                in_valid = 0;
	logic                stall = 0;
	lvca_pkg::lvca_pkt_s in_pkt = '0;
	logic [5:0]          in_ready;
	logic [5:0]          cred_ret;
	logic [5:0][3:0]     cred_init = 24'h22_2222;
	logic                out_valid;
	logic                rel_valid;
	logic                rel_isoc;
	logic [2:0]          out_vc;
	logic [2:0]          rel_vc;
	lvca_pkg::lvca_pkt_s out_pkt;
	logic                wb_cyc = 0;
	logic                wb_stb = 0;
	logic                wb_we = 0;
	logic [7:0]          wb_adr = 8'h00;
	logic [31:0]         wb_dat = 32'h0000_0000;
	logic [31:0]         wb_dat_o;
	logic [31:0]         rd;
	logic                wb_ack_o;
	logic [3:0]          wb_sel = 4'h0;
	logic                mode_exp = 0;
	logic [2:0]          qv[$];
	lvca_pkg::lvca_pkt_s qp[$];
	int                  bad_count = 0;
	int                  n_tests = 0;
	// Kind, vc without flag or in normal mode, vc with flag in isoc mode.
	logic [11:0]         rows[9] = '{12'h003, 12'h114, 12'h214, 12'h325, 12'h425,
		12'h500, 12'h611, 12'h703, 12'h814};

	lvca_arbiter #(.CW(4)) u_lvca_arbiter (.clk(clk), .nrst(nrst), .warm_rst_n(warm_rst_n),
		.in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready), .cred_init(cred_init),
		.cred_ret(cred_ret), .out_valid(out_valid), .out_vc(out_vc), .out_pkt(out_pkt),
		.rel_valid(rel_valid), .rel_vc(rel_vc), .rel_isoc(rel_isoc), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	lvca_far_end u_lvca_far_end (.clk(clk), .nrst(nrst), .stall(stall),
		.out_valid(out_valid), .out_vc(out_vc), .cred_ret(cred_ret));

	// Clock at 50 ns period.
	always #25 clk = ~clk;

	// Issued packets are queued so pulses are never missed between checks.
	always @(posedge clk)
	begin
		if (out_valid === 1'b1)
		begin
			qv.push_back(out_vc);
			qp.push_back(out_pkt);
		end
		// Every issue frees one buffer; the lane flag follows the mode the bench set.
		if (nrst === 1'b1 && (out_valid === 1'b1 || rel_valid === 1'b1))
		begin
			chk_w(32'(rel_valid), 32'(out_valid));
			chk_w(32'(rel_vc), 32'(out_vc));
			chk_w(32'(rel_isoc), 32'(mode_exp && out_vc >= 3'h3));
		end
	end

	task automatic end_of_test;
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pkt(input lvca_pkg::lvca_pkt_s got, input lvca_pkg::lvca_pkt_s exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single Wishbone cycle; the wait is bounded only by the watchdog.
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		wb_sel <= 4'hf;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 0;
		wb_stb <= 0;
		@(posedge clk);
	endtask

	// Offer a packet and hold it until its target slot has room.
	task automatic send(input lvca_pkg::lvca_pkt_s p, input logic [2:0] tv);
		@(posedge clk);
		in_valid <= 1;
		in_pkt <= p;
		do @(posedge clk); while (in_ready[tv] !== 1'b1);
		in_valid <= 0;
	endtask

	function automatic lvca_pkg::lvca_pkt_s mk(input logic [3:0] k, input logic f,
		input logic pp, input logic rti);
		return '{lvca_pkg::lvca_kind_e'(k), f, pp, rti, {28'h000_0000, k}};
	endfunction

	task automatic expect_out(input logic [2:0] v, input lvca_pkg::lvca_pkt_s p);
		for (int k = 0; k < 60 && qv.size() == 0; k++)
			@(posedge clk);
		chk_w(32'(qv.size() != 0), 32'h0000_0001);
		if (qv.size() != 0)
		begin
			chk_w(32'(qv.pop_front()), 32'(v));
			chk_pkt(qp.pop_front(), p);
		end
	endtask

	// Run every kind, with and without the priority flag, in the current mode.
	task automatic run_table(input logic m);
		lvca_pkg::lvca_pkt_s p;
		logic [2:0] v;
		for (int i = 0; i < 18; i++)
		begin
			p = mk(rows[i/2][11:8], i[0], 0, 0);
			v = (m && i[0]) ? rows[i/2][2:0] : rows[i/2][6:4];
			send(p, v);
			expect_out(v, p);
		end
	endtask

	// A reply behind a posted write that is stuck for lack of credit.
	task automatic posted_block(input logic fast);
		stall <= 1;
		repeat (2) send(mk(4'h0, 0, 0, 0), 3'h0);
		repeat (2) expect_out(3'h0, mk(4'h0, 0, 0, 0));
		send(mk(4'h0, 0, 0, 0), 3'h0);
		send(mk(4'h3, 0, 1, 0), 3'h2);
		if (fast)
			expect_out(3'h2, mk(4'h3, 0, 1, 0));
		else
			repeat (12) @(posedge clk);
		chk_w(qv.size(), 32'(0));
		// While held back, the posted and reply slots both show as occupied.
		if (!fast)
		begin
			wb_xfer(0, `LVCA_STATUS_OFS, 0);
			chk_w(rd, 32'h0000_0500);
		end
		stall <= 0;
		expect_out(3'h0, mk(4'h0, 0, 0, 0));
		if (!fast)
			expect_out(3'h2, mk(4'h3, 0, 1, 0));
	endtask

	// The watchdog covers 30000 cycles, roughly a hundred times the expected run.
	initial
	begin
		repeat (30000) @(posedge clk);
		bad_count++;
		end_of_test;
	end

	initial
	begin
		repeat (8) @(posedge clk);
		chk_w(32'(out_valid), 32'(0));
		nrst <= 1;
		wb_xfer(0, `LVCA_CTRL_OFS, 0);
		chk_w(rd, `LVCA_CTRL_RESET);
		wb_xfer(0, `LVCA_STATUS_OFS, 0);
		chk_w(rd & 32'h0000_0001, 32'h0000_0000);
		wb_xfer(0, 8'h40, 0);
		chk_w(rd, 32'h0000_0000);
		run_table(0);
		// A locally produced reply to a flagged request gets the flag.
		send(mk(4'h3, 0, 0, 1), 3'h2);
		expect_out(3'h2, mk(4'h3, 1, 0, 1));
		posted_block(0);
		// Nonposted lane runs dry; posted and replies must still flow.
		stall <= 1;
		repeat (2) send(mk(4'h2, 0, 0, 0), 3'h1);
		repeat (2) expect_out(3'h1, mk(4'h2, 0, 0, 0));
		send(mk(4'h2, 0, 0, 0), 3'h1);
		send(mk(4'h0, 0, 0, 0), 3'h0);
		expect_out(3'h0, mk(4'h0, 0, 0, 0));
		send(mk(4'h4, 0, 0, 0), 3'h2);
		expect_out(3'h2, mk(4'h4, 0, 0, 0));
		stall <= 0;
		expect_out(3'h1, mk(4'h2, 0, 0, 0));
		wb_xfer(1, `LVCA_CTRL_OFS, 32'h0000_0002);
		posted_block(1);
		wb_xfer(1, `LVCA_CTRL_OFS, 32'h0000_0001);
		wb_xfer(0, `LVCA_CTRL_OFS, 0);
		chk_w(rd, 32'h0000_0001);
		wb_xfer(0, `LVCA_STATUS_OFS, 0);
		chk_w(rd & 32'h0000_0001, 32'h0000_0000);
		warm_rst_n <= 0;
		repeat (4) @(posedge clk);
		warm_rst_n <= 1;
		repeat (6) @(posedge clk);
		wb_xfer(0, `LVCA_STATUS_OFS, 0);
		chk_w(rd & 32'h0000_0001, 32'h0000_0001);
		mode_exp <= 1;
		run_table(1);
		// In high-priority mode a reply to a flagged request takes the time-critical lane.
		send(mk(4'h3, 0, 0, 1), 3'h5);
		expect_out(3'h5, mk(4'h3, 1, 0, 1));
		repeat (8) @(posedge clk);
		chk_w(32'(qv.size()), 32'h0000_0000);
		end_of_test;
	end
endmodule

/* File: sim/lvca_far_end.sv */
// Far link partner model that sinks issued packets and hands back buffer credits.
`timescale 1ns/1ps

module lvca_far_end
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       stall,
	input  wire logic       out_valid,
	input  wire logic [2:0] out_vc,
	output logic      [5:0] cred_ret
);
	logic [5:0][3:0] owe;

	// Credits owed per channel; a stall keeps them back so a lane can run dry.
	always_ff @(posedge clk)
	begin
		for (int v = 0; v < 6; v++)
		begin
			if (!nrst)
				owe[v] <= 4'h0;
			else
				owe[v] <= owe[v] + 4'((out_valid && out_vc == 3'(v)) ? 1 : 0)
					- 4'(cred_ret[v]);
		end
	end

	// One return pulse per cycle and channel, only while not stalled.
	always_comb
	begin
		for (int v = 0; v < 6; v++)
			cred_ret[v] = !stall && owe[v] != 4'h0;
	end
endmodule
